// ===== core/lsu_pkg.sv
// Package with register map, PID codes, field positions and carrier types of the USB function registers
package lsu_pkg;

  // Register offsets in the special function register space
  localparam logic [7:0] ADDR_PRESCALER = 8'hE1;
  localparam logic [7:0] ADDR_EP12_TXD  = 8'hE6;
  localparam logic [7:0] ADDR_EP0_TXD   = 8'hE7;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hE8;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'hE9;
  localparam logic [7:0] ADDR_EP0_CTRL  = 8'hEA;
  localparam logic [7:0] ADDR_EP12_CTRL = 8'hEB;
  localparam logic [7:0] ADDR_EP_CTRL   = 8'hEC;
  localparam logic [7:0] ADDR_EP0_STAT  = 8'hED;
  localparam logic [7:0] ADDR_DEV_ADDR  = 8'hEE;
  localparam logic [7:0] ADDR_EP0_RXD   = 8'hEF;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Packet identifiers
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK   = 4'h2;
  localparam logic [3:0] PID_NAK   = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;

  // Field positions
  localparam int CTL_TSEQ  = 7;
  localparam int CTL_STALL = 6;
  localparam int CTL_TXE   = 5;
  localparam int CTL_RXE   = 4;
  localparam int CTL_SEL   = 6;
  localparam int FLG_TXD0  = 4;
  localparam int FLG_RXD0  = 3;
  localparam int EPC_EP2E  = 3;
  localparam int EPC_EP1E  = 2;
  localparam int EPC_STL2  = 1;
  localparam int EPC_STL1  = 0;
  localparam int ADR_EN    = 7;

  localparam logic [3:0] EP_ZERO   = 4'h0;
  localparam logic [3:0] EP_ONE    = 4'h1;
  localparam logic [3:0] EP_TWO    = 4'h2;
  localparam logic [3:0] COUNT_MAX = 4'hF;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W     = 8;

  typedef struct packed {
    logic [3:0] pid;
    logic [6:0] addr;
    logic [3:0] ep;
  } lsu_token_type;

  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] len;
    logic [7:0] data;
  } lsu_reply_type;

endpackage : lsu_pkg

// ===== core/lsu_fifo.sv
// Receive byte FIFO with valid/ready on both sides and registered flags
module lsu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  // Flags registered from the next count so both sides see honest full and empty
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_q     <= count_d;
      in_ready_o  <= (count_d != (AW+1)'(DEPTH));
      out_valid_o <= (count_d != '0);
    end
  end

  fifo_bound_a: assert property (@(posedge mclk_i) disable iff (rst_i) count_q <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : lsu_fifo

// ===== core/lsu_usb_regs.sv
// Low-speed USB function register block: endpoint status, data registers and clock prescaler
// Summary of operation
// R1: Received DATA0/DATA1 PID on endpoint 0 is compared with the expected sequence bit.
// R2: Setup-detect status flag sets when an accepted token carries the SETUP PID.
// R3: IN-detect status flag sets when an accepted token is an IN token.
// R4: OUT-detect status flag sets when an accepted token is an OUT token.
// R5: Low four status bits report bytes received in the latest accepted DATA packet.
// R6: USB tick is the MCU clock halved, then divided by prescaler plus one.
// R7: Software loads the prescaler so the USB tick rate equals 6 MHz.
// R8: Only 12, 24, 36 MHz MCU clocks, with prescaler 0, 1, 2, are supported.
// R9: Eight-bit endpoint 0 receive register plus endpoint 0 and 1/2 transmit registers.
// R10: Endpoint 0 IN gets NAK when transmit enable clear or transmit-done flag set.
// R11: Tokens answered only while function enabled and address field matches.
// R12: Every register clears to zero on system reset.
module lsu_usb_regs (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic                  sfr_rd_i,
  input  wire logic [7:0]            sfr_wdata_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire logic                  tok_valid_i,
  input  wire lsu_pkg::lsu_token_type tok_i,
  input  wire logic                  dpid_valid_i,
  input  wire logic [3:0]            dpid_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_data_i,
  input  wire logic                  rx_end_i,
  output logic                       rx_ready_o,
  input  wire logic                  ep0_tx_done_i,
  output logic                       reply_valid_o,
  output lsu_pkg::lsu_reply_type     reply_o,
  output logic                       usb_tick_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_DATA, ST_COLLECT} lsu_rx_state_type;

  lsu_rx_state_type rx_state_q;
  logic [7:0] usb_clock_prescaler_q;
  logic [7:0] endpoint_one_two_tx_data_q;
  logic [7:0] endpoint_zero_tx_data_q;
  logic [7:0] usb_interrupt_enables_q;
  logic [7:0] endpoint_zero_tx_control_q;
  logic [7:0] endpoint_one_two_tx_control_q;
  logic [7:0] usb_endpoint_control_q;
  logic [7:0] usb_device_address_q;
  logic       rx_sequence_expect_q;
  logic       setup_seen_q;
  logic       in_seen_q;
  logic       out_seen_q;
  logic [3:0] ep0_rx_byte_count_q;
  logic       ep0_transmit_done_flag_q;
  logic       ep0_receive_done_flag_q;
  logic       setup_phase_q;
  logic       accept_q;
  logic [8:0] div_cnt_q;
  logic [8:0] div_last;
  logic       usb_function_enable;
  logic [6:0] device_address_field;
  logic       tok_hit;
  logic       tok_ep0;
  logic       seq_ok;
  logic       take_data;
  logic       push;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       rxd_pop;
  logic       flags_wr;
  logic [7:0] status_rd;

  function automatic logic wr_hit(input logic [7:0] adr);
    return sfr_wr_i && (sfr_addr_i == adr);
  endfunction : wr_hit

  assign usb_function_enable  = usb_device_address_q[lsu_pkg::ADR_EN];
  assign device_address_field = usb_device_address_q[6:0];
  assign tok_hit = tok_valid_i && usb_function_enable && (tok_i.addr == device_address_field);  // R11
  assign tok_ep0 = tok_hit && (tok_i.ep == lsu_pkg::EP_ZERO);
  assign seq_ok  = (dpid_i == lsu_pkg::PID_DATA1) == rx_sequence_expect_q;  // R1
  // Refused packets leave the count alone so software still sees the last good length
  assign take_data = seq_ok && (setup_phase_q || (!endpoint_zero_tx_control_q[lsu_pkg::CTL_STALL]
                     && endpoint_zero_tx_control_q[lsu_pkg::CTL_RXE] && !ep0_receive_done_flag_q));  // R1
  assign push    = (rx_state_q == ST_COLLECT) && accept_q && rx_valid_i && rx_ready_o;
  assign rxd_pop = sfr_rd_i && (sfr_addr_i == lsu_pkg::ADDR_EP0_RXD) && fifo_out_valid;
  assign flags_wr = wr_hit(lsu_pkg::ADDR_IRQ_FLAGS);
  assign status_rd = {rx_sequence_expect_q, setup_seen_q, in_seen_q, out_seen_q, ep0_rx_byte_count_q};

  // Received bytes wait here until the CPU reads them; a full buffer stalls the receiver
  lsu_fifo #(
    .WIDTH(lsu_pkg::DATA_W),
    .DEPTH(lsu_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .in_valid_i (push),
    .in_ready_o (rx_ready_o),
    .in_data_i  (rx_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(rxd_pop),
    .out_data_o (fifo_out_data)
  );

  // Clock divide: halve, then divide by prescaler+1, giving a period of 2*(p+1)
  assign div_last = {usb_clock_prescaler_q, 1'b1};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_cnt_q  <= '0;
      usb_tick_o <= 1'b0;
    end else if (div_cnt_q >= div_last) begin
      div_cnt_q  <= '0;  // R6
      usb_tick_o <= 1'b1;
    end else begin
      div_cnt_q  <= div_cnt_q + 1'b1;
      usb_tick_o <= 1'b0;
    end
  end

  // Software-written registers; all clear on reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      usb_clock_prescaler_q         <= lsu_pkg::REG_RESET;  // R12
      endpoint_one_two_tx_data_q    <= lsu_pkg::REG_RESET;
      endpoint_zero_tx_data_q       <= lsu_pkg::REG_RESET;
      usb_interrupt_enables_q       <= lsu_pkg::REG_RESET;
      endpoint_one_two_tx_control_q <= lsu_pkg::REG_RESET;
      usb_endpoint_control_q        <= lsu_pkg::REG_RESET;
      usb_device_address_q          <= lsu_pkg::REG_RESET;
    end else begin
      if (wr_hit(lsu_pkg::ADDR_PRESCALER)) usb_clock_prescaler_q <= sfr_wdata_i;  // R7
      if (wr_hit(lsu_pkg::ADDR_EP12_TXD)) endpoint_one_two_tx_data_q <= sfr_wdata_i;  // R9
      if (wr_hit(lsu_pkg::ADDR_EP0_TXD)) endpoint_zero_tx_data_q <= sfr_wdata_i;  // R9
      if (wr_hit(lsu_pkg::ADDR_IRQ_EN)) usb_interrupt_enables_q <= sfr_wdata_i;
      if (wr_hit(lsu_pkg::ADDR_EP12_CTRL)) endpoint_one_two_tx_control_q <= sfr_wdata_i;
      if (wr_hit(lsu_pkg::ADDR_EP_CTRL)) usb_endpoint_control_q <= {3'h0, sfr_wdata_i[4:0]};
      if (wr_hit(lsu_pkg::ADDR_DEV_ADDR)) usb_device_address_q <= sfr_wdata_i;
    end
  end

  // Endpoint 0 control; a SETUP token lifts a forced stall, overriding a same-cycle write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      endpoint_zero_tx_control_q <= lsu_pkg::REG_RESET;
    end else begin
      if (wr_hit(lsu_pkg::ADDR_EP0_CTRL)) endpoint_zero_tx_control_q <= sfr_wdata_i;
      if (tok_ep0 && tok_i.pid == lsu_pkg::PID_SETUP) endpoint_zero_tx_control_q[lsu_pkg::CTL_STALL] <= 1'b0;
    end
  end

  // Done flags: writing 0 clears, a hardware set in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ep0_transmit_done_flag_q <= 1'b0;
      ep0_receive_done_flag_q  <= 1'b0;
    end else begin
      if (ep0_tx_done_i) begin
        ep0_transmit_done_flag_q <= 1'b1;
      end else if (flags_wr && !sfr_wdata_i[lsu_pkg::FLG_TXD0]) begin
        ep0_transmit_done_flag_q <= 1'b0;
      end
      if (rx_state_q == ST_COLLECT && rx_end_i && accept_q) begin
        ep0_receive_done_flag_q <= 1'b1;
      end else if (flags_wr && !sfr_wdata_i[lsu_pkg::FLG_RXD0]) begin
        ep0_receive_done_flag_q <= 1'b0;
      end
    end
  end

  // Endpoint 0 status: last token type and byte count
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_sequence_expect_q <= 1'b0;
      setup_seen_q         <= 1'b0;
      in_seen_q            <= 1'b0;
      out_seen_q           <= 1'b0;
      ep0_rx_byte_count_q  <= '0;
    end else begin
      if (wr_hit(lsu_pkg::ADDR_EP0_STAT)) rx_sequence_expect_q <= sfr_wdata_i[7];
      if (tok_ep0) begin
        setup_seen_q <= (tok_i.pid == lsu_pkg::PID_SETUP);  // R2
        in_seen_q    <= (tok_i.pid == lsu_pkg::PID_IN);  // R3
        out_seen_q   <= (tok_i.pid == lsu_pkg::PID_OUT);  // R4
      end
      if (rx_state_q == ST_WAIT_DATA && dpid_valid_i && take_data) begin
        ep0_rx_byte_count_q <= '0;  // R5
      end else if (push && ep0_rx_byte_count_q != lsu_pkg::COUNT_MAX) begin
        ep0_rx_byte_count_q <= ep0_rx_byte_count_q + 1'b1;  // R5
      end
    end
  end

  // Data phase after OUT or SETUP to endpoint 0
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_state_q    <= ST_IDLE;
      setup_phase_q <= 1'b0;
      accept_q      <= 1'b0;
    end else if (tok_ep0 && (tok_i.pid == lsu_pkg::PID_OUT || tok_i.pid == lsu_pkg::PID_SETUP)) begin
      rx_state_q    <= ST_WAIT_DATA;
      setup_phase_q <= (tok_i.pid == lsu_pkg::PID_SETUP);
      accept_q      <= 1'b0;
    end else begin
      case (rx_state_q)
        ST_WAIT_DATA: begin
          if (dpid_valid_i) begin
            rx_state_q <= ST_COLLECT;
            // Wrong sequence means a retried packet: data dropped but still acknowledged
            accept_q <= take_data;  // R1
          end
        end
        ST_COLLECT: begin
          if (rx_end_i) rx_state_q <= ST_IDLE;
        end
        default: rx_state_q <= ST_IDLE;
      endcase
    end
  end

  // Handshake or data reply, one cycle after its cause
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reply_valid_o <= 1'b0;
      reply_o       <= '0;
    end else begin
      reply_valid_o <= 1'b0;
      if (rx_state_q == ST_COLLECT && rx_end_i) begin
        reply_valid_o <= 1'b1;
        reply_o       <= '0;
        if (setup_phase_q || accept_q) begin
          reply_o.pid <= lsu_pkg::PID_ACK;
        end else if (endpoint_zero_tx_control_q[lsu_pkg::CTL_STALL]) begin
          reply_o.pid <= lsu_pkg::PID_STALL;
        end else if (!endpoint_zero_tx_control_q[lsu_pkg::CTL_RXE] || ep0_receive_done_flag_q) begin
          reply_o.pid <= lsu_pkg::PID_NAK;
        end else begin
          reply_o.pid <= lsu_pkg::PID_ACK;
        end
      end else if (tok_ep0 && tok_i.pid == lsu_pkg::PID_IN) begin
        reply_valid_o <= 1'b1;
        reply_o       <= '0;
        if (endpoint_zero_tx_control_q[lsu_pkg::CTL_STALL]) begin
          reply_o.pid <= lsu_pkg::PID_STALL;
        end else if (!endpoint_zero_tx_control_q[lsu_pkg::CTL_TXE] || ep0_transmit_done_flag_q) begin
          reply_o.pid <= lsu_pkg::PID_NAK;  // R10
        end else begin
          reply_o.pid  <= endpoint_zero_tx_control_q[lsu_pkg::CTL_TSEQ] ? lsu_pkg::PID_DATA1 : lsu_pkg::PID_DATA0;
          reply_o.len  <= endpoint_zero_tx_control_q[3:0];
          reply_o.data <= endpoint_zero_tx_data_q;
        end
      end else if (tok_hit && tok_i.pid == lsu_pkg::PID_IN &&
                   (tok_i.ep == lsu_pkg::EP_ONE || tok_i.ep == lsu_pkg::EP_TWO)) begin
        reply_valid_o <= 1'b1;
        reply_o       <= '0;
        if (tok_i.ep == lsu_pkg::EP_ONE ? usb_endpoint_control_q[lsu_pkg::EPC_STL1]
                                        : usb_endpoint_control_q[lsu_pkg::EPC_STL2]) begin
          reply_o.pid <= lsu_pkg::PID_STALL;
        end else if (!endpoint_one_two_tx_control_q[lsu_pkg::CTL_TXE] ||
                     (endpoint_one_two_tx_control_q[lsu_pkg::CTL_SEL] != (tok_i.ep == lsu_pkg::EP_TWO)) ||
                     !(tok_i.ep == lsu_pkg::EP_ONE ? usb_endpoint_control_q[lsu_pkg::EPC_EP1E]
                                                   : usb_endpoint_control_q[lsu_pkg::EPC_EP2E])) begin
          reply_o.pid <= lsu_pkg::PID_NAK;
        end else begin
          reply_o.pid  <= endpoint_one_two_tx_control_q[lsu_pkg::CTL_TSEQ] ? lsu_pkg::PID_DATA1
                                                                           : lsu_pkg::PID_DATA0;
          reply_o.len  <= endpoint_one_two_tx_control_q[3:0];
          reply_o.data <= endpoint_one_two_tx_data_q;
        end
      end
    end
  end

  // Register read port; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= lsu_pkg::REG_RESET;
    end else if (sfr_rd_i) begin
      if (sfr_addr_i == lsu_pkg::ADDR_PRESCALER) begin
        sfr_rdata_o <= usb_clock_prescaler_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP12_TXD) begin
        sfr_rdata_o <= endpoint_one_two_tx_data_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP0_TXD) begin
        sfr_rdata_o <= endpoint_zero_tx_data_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_IRQ_FLAGS) begin
        sfr_rdata_o <= {3'h0, ep0_transmit_done_flag_q, ep0_receive_done_flag_q, 3'h0};
      end else if (sfr_addr_i == lsu_pkg::ADDR_IRQ_EN) begin
        sfr_rdata_o <= usb_interrupt_enables_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP0_CTRL) begin
        sfr_rdata_o <= endpoint_zero_tx_control_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP12_CTRL) begin
        sfr_rdata_o <= endpoint_one_two_tx_control_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP_CTRL) begin
        sfr_rdata_o <= usb_endpoint_control_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP0_STAT) begin
        sfr_rdata_o <= status_rd;  // R5
      end else if (sfr_addr_i == lsu_pkg::ADDR_DEV_ADDR) begin
        sfr_rdata_o <= usb_device_address_q;
      end else if (sfr_addr_i == lsu_pkg::ADDR_EP0_RXD) begin
        sfr_rdata_o <= fifo_out_valid ? fifo_out_data : lsu_pkg::REG_RESET;  // R9
      end else begin
        sfr_rdata_o <= lsu_pkg::REG_RESET;
      end
    end
  end

  tick_period_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R6
    usb_tick_o && usb_clock_prescaler_q == 8'h00 && $stable(usb_clock_prescaler_q) |=> !usb_tick_o ##1 usb_tick_o)
    else $error("tick period wrong for prescaler zero");
  tick_cause_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R6
    usb_tick_o |-> $past(div_cnt_q) >= $past(div_last) && div_cnt_q == 9'h000)
    else $error("tick without terminal count");
  setup_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R2
    tok_ep0 && tok_i.pid == lsu_pkg::PID_SETUP |=> setup_seen_q && !in_seen_q && !out_seen_q)
    else $error("setup flag not set");
  in_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R3
    tok_ep0 && tok_i.pid == lsu_pkg::PID_IN |=> in_seen_q && !setup_seen_q && !out_seen_q)
    else $error("in flag not set");
  out_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R4
    tok_ep0 && tok_i.pid == lsu_pkg::PID_OUT |=> out_seen_q && !setup_seen_q && !in_seen_q)
    else $error("out flag not set");
  byte_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R5
    push && ep0_rx_byte_count_q != lsu_pkg::COUNT_MAX |=> ep0_rx_byte_count_q == $past(ep0_rx_byte_count_q) + 4'h1)
    else $error("byte count did not advance");
  seq_check_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R1
    rx_state_q == ST_WAIT_DATA && dpid_valid_i && !seq_ok && !tok_valid_i |=> !accept_q ##0 !push)
    else $error("mismatched sequence accepted");
  in_nak_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R10
    tok_ep0 && tok_i.pid == lsu_pkg::PID_IN && !(rx_state_q == ST_COLLECT && rx_end_i)
    && !endpoint_zero_tx_control_q[lsu_pkg::CTL_STALL]
    && (!endpoint_zero_tx_control_q[lsu_pkg::CTL_TXE] || ep0_transmit_done_flag_q)
    |=> reply_valid_o && reply_o.pid == lsu_pkg::PID_NAK)
    else $error("endpoint 0 IN not refused");
  token_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R11
    tok_valid_i && !usb_function_enable |=> $stable({setup_seen_q, in_seen_q, out_seen_q}))
    else $error("token taken while disabled");
  tx_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // R9
    sfr_rd_i && sfr_addr_i == lsu_pkg::ADDR_EP0_TXD |=> sfr_rdata_o == $past(endpoint_zero_tx_data_q))
    else $error("transmit data readback wrong");
  reset_clear_a: assert property (@(posedge mclk_i)  // R12
    rst_i |=> usb_clock_prescaler_q == 8'h00 && status_rd == 8'h00 && endpoint_zero_tx_control_q == 8'h00
    && usb_device_address_q == 8'h00 && !reply_valid_o && sfr_rdata_o == 8'h00)
    else $error("register not cleared by reset");

endmodule : lsu_usb_regs

// ===== tb/lsu_host_model.sv
// Host controller model driving tokens, data packets and end of packet toward the function
module lsu_host_model (
  input  wire logic              mclk_i,
  input  wire logic              rx_ready_i,
  output lsu_pkg::lsu_token_type tok_o,
  output logic                   tok_valid_o,
  output logic                   dpid_valid_o,
  output logic [3:0]             dpid_o,
  output logic                   rx_valid_o,
  output logic [7:0]             rx_data_o,
  output logic                   rx_end_o,
  output logic                   tx_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tok_valid_o, dpid_valid_o, rx_valid_o, rx_end_o, tx_done_o} = 5'h00;
    tok_o = '0;
    dpid_o = 4'h0;
    rx_data_o = 8'h00;
  end
  task automatic token(input logic [3:0] pid, input logic [6:0] addr, input logic [3:0] ep);
    @(negedge mclk_i);
    tok_o = '{pid: pid, addr: addr, ep: ep};
    tok_valid_o = 1'b1;
    @(negedge mclk_i);
    tok_valid_o = 1'b0;
    tok_o = ~tok_o;
  endtask : token
  // Gap above zero makes a slow host; released lines show inverted data, not the stale byte
  task automatic packet(input logic [3:0] pid, input int n, input logic [7:0] base, input int gap);
    @(negedge mclk_i);
    dpid_o = pid;
    dpid_valid_o = 1'b1;
    @(negedge mclk_i);
    dpid_valid_o = 1'b0;
    dpid_o = ~pid;
    for (int i = 0; i < n; i++) begin
      rx_data_o = base + 8'(i);
      rx_valid_o = 1'b1;
      while (rx_ready_i !== 1'b1) @(negedge mclk_i);
      @(negedge mclk_i);
      if (gap > 0) begin
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o;
        repeat (gap) @(negedge mclk_i);
      end
    end
    rx_valid_o = 1'b0;
    if (gap == 0) rx_data_o = ~rx_data_o;
    rx_end_o = 1'b1;
    @(negedge mclk_i);
    rx_end_o = 1'b0;
  endtask : packet
  task automatic tx_done();
    @(negedge mclk_i);
    tx_done_o = 1'b1;
    @(negedge mclk_i);
    tx_done_o = 1'b0;
  endtask : tx_done
endmodule : lsu_host_model

// ===== tb/test_lsu_usb_regs.sv
// Self-checking bench of the USB function register block
module test_lsu_usb_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, rd_d = 1'b0;
  logic [7:0]             sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, rx_d, lf = 8'h4C, b;
  lsu_pkg::lsu_token_type tok;
  lsu_pkg::lsu_reply_type reply_o;
  logic                   tok_v, dpid_v, rx_v, rx_end, rx_rdy, tx_done, reply_valid_o, usb_tick_o;
  logic [3:0]             dpid;
  logic [31:0]            rep_q[$], rd_q[$], e;
  logic [7:0]             regs[12] = '{8'hE0, 8'hE1, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF};
  int                     err_total = 0, total_checks = 0, cyc = 0;

  initial forever #5 mclk_i = ~mclk_i;

  lsu_usb_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .tok_valid_i(tok_v), .tok_i(tok), .dpid_valid_i(dpid_v),
    .dpid_i(dpid), .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_end_i(rx_end), .rx_ready_o(rx_rdy),
    .ep0_tx_done_i(tx_done), .reply_valid_o(reply_valid_o), .reply_o(reply_o), .usb_tick_o(usb_tick_o));
  lsu_host_model host (.mclk_i(mclk_i), .rx_ready_i(rx_rdy), .tok_o(tok), .tok_valid_o(tok_v), .dpid_valid_o(dpid_v),
    .dpid_o(dpid), .rx_valid_o(rx_v), .rx_data_o(rx_d), .rx_end_o(rx_end), .tx_done_o(tx_done));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic step(input string s);
    $display("test %s done", s);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    rd_q.push_back({24'h000000, x});
    @(negedge mclk_i);
    sfr_rd_i = 1'b0;
  endtask : rd
  // Handshakes carry only a PID, so the mask keeps the other fields out of the compare
  task automatic want(input logic [3:0] pid, input logic [11:0] rest, input logic [15:0] mask);
    rep_q.push_back({mask, pid, rest});
  endtask : want
  task automatic tok0(input logic [3:0] pid);
    host.token(pid, 7'h05, lsu_pkg::EP_ZERO);
  endtask : tok0
  task automatic tick_gap(input int p);
    int n;
    wr(lsu_pkg::ADDR_PRESCALER, 8'(p));
    repeat (2) begin
      n = 0;
      do begin
        @(negedge mclk_i);
        n++;
      end while (usb_tick_o !== 1'b1 && n < 50);
    end
    check(16'(n), 16'(2 * (p + 1)));
  endtask : tick_gap

  // Unexpected reads or replies pop a mask of zero against FFFF, which always mismatches
  always @(posedge mclk_i) begin
    rd_d <= sfr_rd_i;
    cyc <= cyc + 1;
    if (rd_d) begin
      e = (rd_q.size() != 0) ? rd_q.pop_front() : 32'h0000FFFF;
      check({8'h00, sfr_rdata_o}, e[15:0]);
    end
    if (reply_valid_o === 1'b1) begin
      e = (rep_q.size() != 0) ? rep_q.pop_front() : 32'h0000FFFF;
      check(reply_o & e[31:16], e[15:0]);
    end
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    step("reset values");
    for (int p = 0; p < 3; p++) tick_gap(p);
    step("prescaler");
    lf = lfsr(lf);
    wr(8'hE7, lf);
    rd(8'hE7, lf);
    wr(8'hE6, ~lf);
    rd(8'hE6, ~lf);
    step("data registers");
    tok0(lsu_pkg::PID_IN);
    wr(8'hEE, 8'h05);
    tok0(lsu_pkg::PID_IN);
    wr(8'hEE, 8'h85);
    host.token(lsu_pkg::PID_IN, 7'h06, lsu_pkg::EP_ZERO);
    want(lsu_pkg::PID_NAK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_IN);
    rd(8'hED, 8'h20);
    wr(8'hEA, 8'hA3);
    want(lsu_pkg::PID_DATA1, {4'h3, lf}, 16'hFFFF);
    tok0(lsu_pkg::PID_IN);
    host.tx_done();
    rd(8'hE8, 8'h10);
    want(lsu_pkg::PID_NAK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_IN);
    wr(8'hEC, 8'h04);
    wr(8'hEB, 8'h23);
    want(lsu_pkg::PID_DATA0, {4'h3, ~lf}, 16'hFFFF);
    host.token(lsu_pkg::PID_IN, 7'h05, lsu_pkg::EP_ONE);
    want(lsu_pkg::PID_NAK, 12'h000, 16'hF000);
    host.token(lsu_pkg::PID_IN, 7'h05, lsu_pkg::EP_TWO);
    step("in tokens");
    wr(8'hE8, 8'h00);
    wr(8'hEA, 8'h10);
    b = lfsr(lf);
    want(lsu_pkg::PID_ACK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_OUT);
    host.packet(lsu_pkg::PID_DATA0, 2, b, 0);
    rd(8'hED, 8'h12);
    rd(8'hE8, 8'h08);
    rd(8'hEF, b);
    rd(8'hEF, b + 8'h01);
    rd(8'hEF, 8'h00);
    wr(8'hE8, 8'h00);
    want(lsu_pkg::PID_ACK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_OUT);
    host.packet(lsu_pkg::PID_DATA1, 3, b, 2);
    rd(8'hED, 8'h12);
    rd(8'hEF, 8'h00);
    wr(8'hED, 8'h80);
    wr(8'hE8, 8'h00);
    want(lsu_pkg::PID_ACK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_OUT);
    host.packet(lsu_pkg::PID_DATA1, 1, b, 0);
    rd(8'hED, 8'h91);
    rd(8'hEF, b);
    step("out data");
    wr(8'hE8, 8'h00);
    wr(8'hEA, 8'h50);
    want(lsu_pkg::PID_STALL, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_OUT);
    host.packet(lsu_pkg::PID_DATA1, 0, b, 0);
    rd(8'hED, 8'h91);
    want(lsu_pkg::PID_ACK, 12'h000, 16'hF000);
    tok0(lsu_pkg::PID_SETUP);
    host.packet(lsu_pkg::PID_DATA1, 8, b, 1);
    rd(8'hEA, 8'h10);
    rd(8'hED, 8'hC8);
    check(16'(rx_rdy), 16'h0000);
    for (int i = 0; i < 8; i++) rd(8'hEF, b + 8'(i));
    check(16'(rx_rdy), 16'h0001);
    step("setup");
    repeat (4) @(negedge mclk_i);
    check(16'(rd_q.size() + rep_q.size()), 16'h0000);
    test_done();
  end
endmodule : test_lsu_usb_regs
